// *** design/dpath_slice_pkg.sv ***
// constants and helpers shared by the data path slice buffers
package dpath_slice_pkg;
  localparam int LW_W        = 32;  // longword width per slice
  localparam int PAR_W       = 4;   // one parity bit per byte
  localparam int MASK_W      = 4;   // one byte mask bit per byte
  localparam int BYTE_W      = 8;   // bits per byte lane
  localparam int NUM_LW      = 4;   // longwords per entry per slice
  localparam int NUM_ENT     = 4;   // entries in the multi-entry buffers
  localparam int LW_USED     = 2;   // longwords reachable in a four-slice system
  localparam int IDX_W       = 2;   // width of entry and longword selects
  localparam int FIFO_DEPTH  = 8;   // bridge-side write staging depth
  localparam int DMA_RD_BIT  = 1;   // entry select bit that marks a dma read entry
  localparam int DW_PKT_W    = 2 * IDX_W + MASK_W + LW_W;
  localparam logic SRC_MRB   = 1'b0;  // first-level source: memory read buffer
  localparam logic SRC_MRG   = 1'b1;  // first-level source: merge buffer
  localparam logic OE_DRIVE_N = 1'b0;
  localparam logic OE_FLOAT_N = 1'b1;
  localparam logic [LW_W-1:0]  DATA_RST = 32'h0000_0000;
  localparam logic [PAR_W-1:0] PAR_RST  = 4'h0;
  localparam logic [PAR_W-1:0] PAR_BAD  = 4'hf;

  // even parity, one bit per byte lane
  function automatic logic [PAR_W-1:0] byte_par(input logic [LW_W-1:0] d);
    logic [PAR_W-1:0] p;
    p = '0;
    for (int b = 0; b < PAR_W; b++)
    begin
      p[b] = ^d[b*BYTE_W +: BYTE_W];
    end
    return p;
  endfunction
endpackage

// *** design/stage_fifo.sv ***
// parameterised valid/ready fifo staging bridge-side write data
`timescale 1ns/1ns
module stage_fifo #(
  parameter int WIDTH = 40,
  parameter int DEPTH = 8
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_valid,
  output logic                  o_ready,
  input  wire logic [WIDTH-1:0] i_data,
  output logic                  o_valid,
  input  wire logic             i_ready,
  output logic [WIDTH-1:0]      o_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic             push;
  logic             pop;

  assign o_ready = (count_ff != (AW+1)'(DEPTH));
  assign o_valid = (count_ff != '0);
  assign o_data  = mem[rd_ptr_ff];
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;

  always_ff @(posedge i_clk)
  begin
    if (push)
    begin
      mem[wr_ptr_ff] <= i_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  a_fifo_full_stall: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ((count_ff == (AW+1)'(DEPTH)) && !i_ready) |=> (count_ff == (AW+1)'(DEPTH)))
    else $error("fifo accepts data while full");
  a_fifo_push_count: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (push && !pop) |=> (count_ff == $past(count_ff) + 1'b1))
    else $error("fifo count missed a push");
endmodule // stage_fifo

// *** design/dpath_slice_buffers.sv ***
// one 32-bit data path slice: read, merge, shared, dma write and memory write buffers
`timescale 1ns/1ns
module dpath_slice_buffers #(
  parameter int LW_USED    = dpath_slice_pkg::LW_USED,
  parameter int FIFO_DEPTH = dpath_slice_pkg::FIFO_DEPTH
) (
  input  wire logic        I_REF_CLK,
  input  wire logic        I_RESETN,
  input  wire logic        I_MEM_RD_LD,
  input  wire logic [1:0]  I_MEM_RD_IDX,
  input  wire logic [31:0] I_MEM_DATA,
  input  wire logic [3:0]  I_MEM_PAR,
  input  wire logic        I_MRG_LD,
  input  wire logic        I_IORD_LD,
  input  wire logic [1:0]  I_MRG_IDX,
  input  wire logic [31:0] I_PROC_DATA,
  input  wire logic [3:0]  I_PROC_PAR,
  input  wire logic        I_SH_LD,
  input  wire logic [1:0]  I_LINE_SEL,
  input  wire logic [1:0]  I_SH_LW,
  input  wire logic        I_SH_UNLD,
  input  wire logic [1:0]  I_SH_UNLD_SEL,
  input  wire logic [1:0]  I_SH_UNLD_LW,
  input  wire logic [31:0] I_BRIDGE_DATA,
  output logic [31:0]      O_BRIDGE_DATA,
  output logic             O_BRIDGE_OE_N,
  input  wire logic        I_DW_VALID,
  input  wire logic [1:0]  I_DW_ENTRY,
  input  wire logic [1:0]  I_DW_LW,
  input  wire logic [3:0]  I_DW_MASK,
  output logic             O_DW_READY,
  input  wire logic        I_DW_UNLD,
  input  wire logic [1:0]  I_DW_UNLD_SEL,
  input  wire logic [1:0]  I_DW_UNLD_LW,
  input  wire logic        I_MWB_LD,
  input  wire logic [1:0]  I_MWB_ENTRY,
  input  wire logic [1:0]  I_MWB_LW,
  input  wire logic        I_MWB_UNLD,
  input  wire logic [1:0]  I_MWB_UNLD_SEL,
  input  wire logic [1:0]  I_MWB_UNLD_LW,
  output logic [31:0]      O_MEM_DATA,
  output logic [3:0]       O_MEM_PAR,
  output logic             O_DMA_RD_PERR,
  input  wire logic [3:0]  I_LW_SRC,
  input  wire logic [1:0]  I_PAIR_SEL0,
  input  wire logic [1:0]  I_PAIR_SEL1,
  output logic [63:0]      O_PROC_DATA,
  output logic [7:0]       O_PROC_PAR
);
  localparam int LW_W   = dpath_slice_pkg::LW_W;
  localparam int PAR_W  = dpath_slice_pkg::PAR_W;
  localparam int NUM_LW = dpath_slice_pkg::NUM_LW;
  localparam int NENT   = dpath_slice_pkg::NUM_ENT;
  localparam int UW     = (LW_USED > 1) ? $clog2(LW_USED) : 1;
  localparam int PKT_W  = dpath_slice_pkg::DW_PKT_W;
  localparam int DRB    = dpath_slice_pkg::DMA_RD_BIT;
  localparam int BW     = dpath_slice_pkg::BYTE_W;

  // storage; read, shared and dma write buffers build only LW_USED longwords, merge and memory write buffers keep all NUM_LW
  logic [LW_W-1:0]  mrb_data [LW_USED];
  logic [PAR_W-1:0] mrb_par  [LW_USED];
  logic [LW_W-1:0]  mrg_data [NUM_LW];
  logic [PAR_W-1:0] mrg_par  [NUM_LW];
  logic [LW_W-1:0]  sh_data  [NENT][LW_USED];
  logic [LW_W-1:0]  dw_data  [NENT][LW_USED];
  logic [PAR_W-1:0] dw_mask  [NENT][LW_USED];
  logic [LW_W-1:0]  mwb_data [NENT][NUM_LW];
  logic [PAR_W-1:0] mwb_par  [NENT][NUM_LW];
  logic [NENT-1:0]  dw_full_ff [LW_USED];

  logic [UW-1:0]    mrb_wi;
  logic [UW-1:0]    sh_wi;
  logic [UW-1:0]    sh_ri;
  logic [UW-1:0]    dw_ri;
  logic             sh_ld_ok;
  logic             sh_ld_dma;
  logic [LW_W-1:0]  sh_rd;
  logic             dma_chk_err;
  logic [LW_W-1:0]  bg_data;
  logic             bg_err;
  logic [LW_W-1:0]  mrg_word;
  logic [PAR_W-1:0] mrg_wpar;
  logic [LW_W-1:0]  mwb_rd;
  logic [PAR_W-1:0] mwb_rd_par;

  logic [PKT_W-1:0] fifo_in;
  logic [PKT_W-1:0] fifo_out;
  logic             fifo_valid;
  logic             fifo_take;
  logic [1:0]       hd_ent;
  logic [1:0]       hd_lw;
  logic [PAR_W-1:0] hd_mask;
  logic [LW_W-1:0]  hd_data;
  logic [UW-1:0]    hd_wi;

  logic [LW_W-1:0]  l1_data [NUM_LW];
  logic [PAR_W-1:0] l1_par  [NUM_LW];

  assign mrb_wi = I_MEM_RD_IDX[UW-1:0];
  assign sh_wi  = I_SH_LW[UW-1:0];
  assign sh_ri  = I_SH_UNLD_LW[UW-1:0];
  assign dw_ri  = I_DW_UNLD_LW[UW-1:0];

  // memory read buffer
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_MEM_RD_LD)
    begin
      mrb_data[mrb_wi] <= I_MEM_DATA;
      mrb_par[mrb_wi]  <= I_MEM_PAR;
    end
  end

  // merge / i/o read buffer: i/o read parity is don't-care, never checked
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_MRG_LD)
    begin
      mrg_data[I_MRG_IDX] <= I_PROC_DATA;
      mrg_par[I_MRG_IDX]  <= I_PROC_PAR;
    end
    else if (I_IORD_LD)
    begin
      mrg_data[I_MRG_IDX] <= I_BRIDGE_DATA;
      mrg_par[I_MRG_IDX]  <= dpath_slice_pkg::PAR_RST;
    end
  end

  // shared i/o write / dma read buffer; entry half decides the source
  assign sh_ld_dma = I_LINE_SEL[DRB];
  assign sh_ld_ok  = I_SH_LD;
  assign sh_rd     = sh_data[I_SH_UNLD_SEL][sh_ri];
  assign dma_chk_err = sh_ld_ok && sh_ld_dma &&
                       (dpath_slice_pkg::byte_par(mrb_data[sh_wi]) != mrb_par[sh_wi]);

  always_ff @(posedge I_REF_CLK)
  begin
    if (sh_ld_ok)
    begin
      sh_data[I_LINE_SEL][sh_wi] <= sh_ld_dma ? mrb_data[sh_wi] : I_PROC_DATA;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      O_BRIDGE_DATA <= dpath_slice_pkg::DATA_RST;
      O_BRIDGE_OE_N <= dpath_slice_pkg::OE_FLOAT_N;
    end
    else
    begin
      // pins float except the cycle after an unload, so slices can share them
      O_BRIDGE_OE_N <= I_SH_UNLD ? dpath_slice_pkg::OE_DRIVE_N : dpath_slice_pkg::OE_FLOAT_N;
      if (I_SH_UNLD)
      begin
        O_BRIDGE_DATA <= sh_rd;
      end
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      O_DMA_RD_PERR <= 1'b0;
    end
    else
    begin
      O_DMA_RD_PERR <= dma_chk_err;
    end
  end

  // dma write staging fifo; a head waits while its target slot is occupied
  assign fifo_in = {I_DW_ENTRY, I_DW_LW, I_DW_MASK, I_BRIDGE_DATA};
  assign {hd_ent, hd_lw, hd_mask, hd_data} = fifo_out;
  assign hd_wi     = hd_lw[UW-1:0];
  assign fifo_take = fifo_valid && !dw_full_ff[hd_wi][hd_ent];

  stage_fifo #(
    .WIDTH (PKT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_dw_fifo (
    .i_clk   (I_REF_CLK),
    .i_rst_n (I_RESETN),
    .i_valid (I_DW_VALID),
    .o_ready (O_DW_READY),
    .i_data  (fifo_in),
    .o_valid (fifo_valid),
    .i_ready (fifo_take),
    .o_data  (fifo_out)
  );

  always_ff @(posedge I_REF_CLK)
  begin
    if (fifo_take)
    begin
      dw_data[hd_ent][hd_wi] <= hd_data;
      dw_mask[hd_ent][hd_wi] <= hd_mask;
    end
  end

  // slot occupancy: a fill in the same cycle as an unload wins
  always_ff @(posedge I_REF_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      for (int i = 0; i < LW_USED; i++)
      begin
        dw_full_ff[i] <= '0;
      end
    end
    else
    begin
      if (I_DW_UNLD)
      begin
        dw_full_ff[dw_ri][I_DW_UNLD_SEL] <= 1'b0;
      end
      if (fifo_take)
      begin
        dw_full_ff[hd_wi][hd_ent] <= 1'b1;
      end
    end
  end

  // masked merge with background from the memory read buffer
  assign bg_data = mrb_data[dw_ri];
  assign bg_err  = I_DW_UNLD && (dpath_slice_pkg::byte_par(bg_data) != mrb_par[dw_ri]);

  always_comb
  begin
    mrg_word = bg_data;
    for (int b = 0; b < PAR_W; b++)
    begin
      if (dw_mask[I_DW_UNLD_SEL][dw_ri][b])
      begin
        mrg_word[b*BW +: BW] = dw_data[I_DW_UNLD_SEL][dw_ri][b*BW +: BW];
      end
    end
    // corrupt parity so memory keeps a visible error
    mrg_wpar = dpath_slice_pkg::byte_par(mrg_word)
             ^ (bg_err ? dpath_slice_pkg::PAR_BAD : dpath_slice_pkg::PAR_RST);
  end

  // memory write buffer; merged dma data takes precedence over a processor load
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_DW_UNLD)
    begin
      mwb_data[I_MWB_ENTRY][I_MWB_LW] <= mrg_word;
      mwb_par[I_MWB_ENTRY][I_MWB_LW]  <= mrg_wpar;
    end
    else if (I_MWB_LD)
    begin
      mwb_data[I_MWB_ENTRY][I_MWB_LW] <= I_PROC_DATA;
      mwb_par[I_MWB_ENTRY][I_MWB_LW]  <= I_PROC_PAR;
    end
  end

  assign mwb_rd     = mwb_data[I_MWB_UNLD_SEL][I_MWB_UNLD_LW];
  assign mwb_rd_par = mwb_par[I_MWB_UNLD_SEL][I_MWB_UNLD_LW];

  always_ff @(posedge I_REF_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      O_MEM_DATA <= dpath_slice_pkg::DATA_RST;
      O_MEM_PAR  <= dpath_slice_pkg::PAR_RST;
    end
    else if (I_MWB_UNLD)
    begin
      O_MEM_DATA <= mwb_rd;
      O_MEM_PAR  <= mwb_rd_par;
    end
  end

  // processor output, first level: one source per longword
  always_comb
  begin
    for (int k = 0; k < NUM_LW; k++)
    begin
      if ((k < LW_USED) && (I_LW_SRC[k] == dpath_slice_pkg::SRC_MRB))
      begin
        l1_data[k] = mrb_data[k % LW_USED];
        l1_par[k]  = mrb_par[k % LW_USED];
      end
      else
      begin
        l1_data[k] = mrg_data[k];
        l1_par[k]  = mrg_par[k];
      end
    end
  end

  // second level: which two longwords go out
  always_ff @(posedge I_REF_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      O_PROC_DATA <= {dpath_slice_pkg::DATA_RST, dpath_slice_pkg::DATA_RST};
      O_PROC_PAR  <= {dpath_slice_pkg::PAR_RST, dpath_slice_pkg::PAR_RST};
    end
    else
    begin
      O_PROC_DATA <= {l1_data[I_PAIR_SEL1], l1_data[I_PAIR_SEL0]};
      O_PROC_PAR  <= {l1_par[I_PAIR_SEL1], l1_par[I_PAIR_SEL0]};
    end
  end

  sequence s_unload_req;
    I_SH_UNLD;
  endsequence
  sequence s_drive_word;
    !O_BRIDGE_OE_N && (O_BRIDGE_DATA == $past(sh_rd));
  endsequence

  a_unload_drive: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
    s_unload_req |=> s_drive_word)
    else $error("unloaded word not driven on bridge bus");
  a_bus_float_idle: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
    !I_SH_UNLD |=> O_BRIDGE_OE_N)
    else $error("bridge bus driven without an unload");
  a_dma_perr_flag: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
    (I_SH_LD && I_LINE_SEL[DRB] && (dpath_slice_pkg::byte_par(mrb_data[sh_wi]) != mrb_par[sh_wi]))
    |=> O_DMA_RD_PERR)
    else $error("dma read parity error not reported");
  a_iowr_no_perr: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
    (I_SH_LD && !I_LINE_SEL[DRB]) |=> !O_DMA_RD_PERR)
    else $error("parity reported on an i/o write load");
  a_mwb_unload: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
    I_MWB_UNLD |=> (O_MEM_DATA == $past(mwb_rd)) && (O_MEM_PAR == $past(mwb_rd_par)))
    else $error("memory write buffer unload mismatch");
  a_bad_par_write: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
    (bg_err && !I_MWB_UNLD) ##1 (I_MWB_UNLD && (I_MWB_UNLD_SEL == $past(I_MWB_ENTRY))
      && (I_MWB_UNLD_LW == $past(I_MWB_LW)))
    |=> (O_MEM_PAR != dpath_slice_pkg::byte_par(O_MEM_DATA)))
    else $error("merged word with background error kept good parity");
endmodule // dpath_slice_buffers

// *** sim/bridge_model.sv ***
// bridge-side partner: dma write word source, i/o read loader, shared buffer unloader
`timescale 1ns/1ns
module bridge_model (
  input  wire logic        i_clk,
  input  wire logic        i_ready,
  output logic             o_valid,
  output logic [1:0]       o_entry,
  output logic [1:0]       o_lw,
  output logic [3:0]       o_mask,
  output logic [31:0]      o_data,
  output logic             o_iord_ld,
  output logic [1:0]       o_iord_idx,
  output logic             o_unld,
  output logic [1:0]       o_unld_sel,
  output logic [1:0]       o_unld_lw
);
  logic [39:0] q [$];
  logic [31:0] last = '0;
  logic [31:0] rd_d;
  logic [1:0]  rd_idx;
  logic        rd_pend = '0;
  logic        tk;
  logic        pop;
  int          gap = 0;
  int          wait_n = 0;

  initial
  begin
    {o_valid, o_iord_ld, o_unld} = '0;
    {o_entry, o_lw, o_mask, o_iord_idx, o_unld_sel, o_unld_lw} = '0;
    o_data = ~last;
  end

  task automatic push(input logic [1:0] e, input logic [1:0] l, input logic [3:0] m, input logic [31:0] d);
    q.push_back({e, l, m, d});
  endtask

  task automatic io_rd(input logic [1:0] idx, input logic [31:0] d);
    rd_idx = idx;
    rd_d = d;
    rd_pend = 1'b1;
  endtask

  // strobe left up so back-to-back calls drive the bus without a gap
  task automatic unload(input logic [1:0] s, input logic [1:0] l);
    o_unld = 1'b1;
    o_unld_sel = s;
    o_unld_lw = l;
    @(posedge i_clk);
    #1;
  endtask

  task automatic unload_end;
    o_unld = 1'b0;
  endtask

  // a word and its packet stand until the edge that sees ready
  always @(posedge i_clk)
  begin
    tk = o_valid & i_ready;
    #1;
    if (tk === 1'b1 || o_valid !== 1'b1)
    begin
      if (tk === 1'b1)
        last = o_data;
      pop = !rd_pend && wait_n == 0 && q.size() > 0;
      o_iord_ld = rd_pend;
      o_valid = pop;
      if (rd_pend)
      begin
        o_iord_idx = rd_idx;
        o_data = rd_d;
        last = rd_d;
      end
      else if (pop)
        {o_entry, o_lw, o_mask, o_data} = q.pop_front();
      else
        o_data = ~last; // released bus must not keep the last value
      if (pop)
        wait_n = gap;
      else if (wait_n > 0)
        wait_n--;
      rd_pend = 1'b0;
    end
  end
endmodule // bridge_model

// *** sim/tb_chipset_data_path_slice_buffers.sv ***
// self-checking bench for one data path slice
`timescale 1ns/1ns
module tb_chipset_data_path_slice_buffers;
  integer      seed = 32'h39b1_2cef;
  int          fails = 0;
  int          compares = 0;
  logic        clk = '0;
  logic        rst_n = '0;
  logic        mrd_ld = '0, mrg_ld = '0, sh_ld = '0, dw_unld = '0, mwb_ld = '0, mwb_unld = '0;
  logic [1:0]  mrd_idx = '0, mrg_idx = '0, line_sel = '0, sh_lw = '0, dw_usel = '0, dw_ulw = '0;
  logic [1:0]  mwb_e = '0, mwb_l = '0, mwb_usel = '0, mwb_ulw = '0, ps0 = '0, ps1 = '0;
  logic [3:0]  mem_p = '0, proc_p = '0, lw_src = '0, dw_m, omem_p;
  logic [31:0] mem_d = '0, proc_d = '0, br_d, obr_d, omem_d, d;
  logic [1:0]  p_idx, sh_usel, sh_ulw, dw_e, dw_l;
  logic        iord_ld, sh_unld, dw_v, dw_rdy, oe_n, perr;
  logic [63:0] oproc_d;
  logic [7:0]  oproc_p;
  logic [35:0] e0, e1;
  logic [31:0] mrb [2];
  logic [3:0]  mrbp [2];
  logic [31:0] mrg [4];
  logic [31:0] sh [8];
  logic [31:0] fd [10];
  logic [3:0]  fm [10];
  wire  [1:0]  mrg_idx_w = iord_ld ? p_idx : mrg_idx;

  always #5 clk = ~clk;

  bridge_model pm (.i_clk(clk), .i_ready(dw_rdy), .o_valid(dw_v), .o_entry(dw_e), .o_lw(dw_l), .o_mask(dw_m),
    .o_data(br_d), .o_iord_ld(iord_ld), .o_iord_idx(p_idx), .o_unld(sh_unld), .o_unld_sel(sh_usel),
    .o_unld_lw(sh_ulw));
  dpath_slice_buffers dut_u (.I_REF_CLK(clk), .I_RESETN(rst_n), .I_MEM_RD_LD(mrd_ld), .I_MEM_RD_IDX(mrd_idx),
    .I_MEM_DATA(mem_d), .I_MEM_PAR(mem_p), .I_MRG_LD(mrg_ld), .I_IORD_LD(iord_ld), .I_MRG_IDX(mrg_idx_w),
    .I_PROC_DATA(proc_d), .I_PROC_PAR(proc_p), .I_SH_LD(sh_ld), .I_LINE_SEL(line_sel), .I_SH_LW(sh_lw),
    .I_SH_UNLD(sh_unld), .I_SH_UNLD_SEL(sh_usel), .I_SH_UNLD_LW(sh_ulw), .I_BRIDGE_DATA(br_d),
    .O_BRIDGE_DATA(obr_d), .O_BRIDGE_OE_N(oe_n), .I_DW_VALID(dw_v), .I_DW_ENTRY(dw_e), .I_DW_LW(dw_l),
    .I_DW_MASK(dw_m), .O_DW_READY(dw_rdy), .I_DW_UNLD(dw_unld), .I_DW_UNLD_SEL(dw_usel),
    .I_DW_UNLD_LW(dw_ulw), .I_MWB_LD(mwb_ld), .I_MWB_ENTRY(mwb_e), .I_MWB_LW(mwb_l), .I_MWB_UNLD(mwb_unld),
    .I_MWB_UNLD_SEL(mwb_usel), .I_MWB_UNLD_LW(mwb_ulw), .O_MEM_DATA(omem_d), .O_MEM_PAR(omem_p),
    .O_DMA_RD_PERR(perr), .I_LW_SRC(lw_src), .I_PAIR_SEL0(ps0), .I_PAIR_SEL1(ps1), .O_PROC_DATA(oproc_d),
    .O_PROC_PAR(oproc_p));

  function automatic logic [3:0] par(input logic [31:0] v);
    for (int b = 0; b < 4; b++)
      par[b] = ^v[b*8 +: 8];
  endfunction

  // bad background parity must survive the merge as inverted parity
  function automatic logic [35:0] merge(input logic [31:0] w, input logic [3:0] mk, input int l);
    logic [31:0] r;
    for (int b = 0; b < 4; b++)
      r[b*8 +: 8] = mk[b] ? w[b*8 +: 8] : mrb[l][b*8 +: 8];
    return {(par(mrb[l]) !== mrbp[l]) ? ~par(r) : par(r), r};
  endfunction

  function automatic logic [35:0] lvl(input logic [1:0] k);
    return (k < 2 && lw_src[k] == 1'b0) ? {mrbp[k[0]], mrb[k[0]]} : {par(mrg[k]), mrg[k]};
  endfunction

  task automatic tick;
    @(posedge clk);
    #1;
  endtask

  task automatic check(input logic [71:0] seen, input logic [71:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic mrb_load(input int i);
    mrd_ld = 1'b1;
    mrd_idx = 2'(i);
    mem_d = mrb[i];
    mem_p = mrbp[i];
    tick;
  endtask

  // dw=1 merges a dma write slot against a competing processor load, dw=0 loads processor data
  task automatic flush(input logic dw, input logic [1:0] e, input logic [1:0] l);
    dw_unld = dw;
    mwb_ld = 1'b1;
    {dw_usel, mwb_e, mwb_usel} = {e, e, e};
    {dw_ulw, mwb_l, mwb_ulw} = {l, l, l};
    tick;
    {dw_unld, mwb_ld, mwb_unld} = 3'h1;
    tick;
    mwb_unld = 1'b0;
  endtask

  // generous bound: the sequence needs well under a thousand cycles
  initial
  begin
    #100000;
    fails++;
    complete_run;
  end

  initial
  begin
    repeat (2) @(posedge clk);
    #1;
    check({oe_n, dw_rdy, perr, omem_d, oproc_d[31:0]}, {3'h6, 64'h0});
    rst_n = 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      mrb[i] = $random(seed);
      mrbp[i] = par(mrb[i]);
      mrb_load(i);
    end
    mrd_ld = 1'b0;
    mem_d = ~mem_d;
    for (int i = 0; i < 4; i++)
    begin
      mrg[i] = $random(seed);
      proc_d = mrg[i];
      proc_p = par(mrg[i]);
      mrg_idx = 2'(i);
      mrg_ld = 1'b1;
      tick;
    end
    mrg_ld = 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      lw_src = 4'($random(seed));
      {ps1, ps0} = 4'(i);
      tick;
      e0 = lvl(ps0);
      e1 = lvl(ps1);
      check({oproc_p, oproc_d}, {e1[35:32], e0[35:32], e1[31:0], e0[31:0]});
    end
    d = $random(seed);
    pm.io_rd(2'h2, d);
    repeat (3) tick;
    ps0 = 2'h2;
    tick;
    check(oproc_d[31:0], d);
    for (int i = 0; i < 8; i++)
    begin
      sh[i] = (i >= 4) ? mrb[i & 1] : $random(seed);
      proc_d = sh[i];
      line_sel = 2'(i >> 1);
      sh_lw = 2'(i & 1);
      sh_ld = 1'b1;
      tick;
      check(perr, 1'b0);
    end
    sh_ld = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      pm.unload(2'(i >> 1), 2'(i & 1));
      check({oe_n, obr_d}, {1'b0, sh[i]});
    end
    pm.unload_end;
    tick;
    check(oe_n, 1'b1);
    mrbp[0] = par(mrb[0]) ^ 4'h1;
    mrb_load(0);
    mrd_ld = 1'b0;
    mem_d = ~mem_d;
    line_sel = 2'h2;
    sh_lw = 2'h0;
    sh_ld = 1'b1;
    tick;
    sh_ld = 1'b0;
    check(perr, 1'b1);
    tick;
    check(perr, 1'b0);
    pm.gap = 2;
    for (int i = 0; i < 8; i++)
    begin
      fd[i] = $random(seed);
      fm[i] = 4'($random(seed));
      pm.push(2'(i >> 1), 2'(i & 1), fm[i], fd[i]);
    end
    repeat (30) tick;
    for (int i = 0; i < 8; i++)
    begin
      flush(1'b1, 2'(i >> 1), 2'(i & 1));
      check({omem_p, omem_d}, merge(fd[i], fm[i], i & 1));
    end
    for (int i = 0; i < 4; i++)
    begin
      d = $random(seed);
      proc_d = d;
      proc_p = par(d);
      flush(1'b0, 2'(i), 2'(3 - i));
      check({omem_p, omem_d}, {par(d), d});
    end
    pm.gap = 0;
    for (int i = 0; i < 10; i++)
    begin
      fd[i] = $random(seed);
      fm[i] = 4'($random(seed));
      pm.push(2'h1, 2'h0, fm[i], fd[i]);
    end
    repeat (14) tick;
    check(dw_rdy, 1'b0);
    for (int i = 0; i < 10; i++)
    begin
      repeat (3) tick;
      flush(1'b1, 2'h1, 2'h0);
      check({omem_p, omem_d}, merge(fd[i], fm[i], 0));
    end
    check(dw_rdy, 1'b1);
    complete_run;
  end
endmodule // tb_chipset_data_path_slice_buffers
